// [logic/ebt_consts.vh]
// constants for the expansion bus cycle timing block
`ifndef EBT_CONSTS_VH
`define EBT_CONSTS_VH

// register word indexes on the avalon-mm slave (address is a word index)
`define EBT_IDX_BALE_DELAY 4'h0
`define EBT_IDX_BALE_WIDTH 4'h1
`define EBT_IDX_NARROW_CMD 4'h3
`define EBT_IDX_NARROW_WAIT 4'h4
`define EBT_IDX_WIDE_IO_WAIT 4'h5
`define EBT_IDX_WIDE_MEM_CMD 4'h6
`define EBT_IDX_WIDE_MEM_WAIT 4'h7
`define EBT_IDX_ZW_MIN 4'h8
`define EBT_IDX_CONTROL 4'h9
`define EBT_IDX_STATUS 4'ha

// setting field width and reset values (slow bus profile)
`define EBT_SET_W 4
`define EBT_RST_BALE_DELAY 4'h0
`define EBT_RST_BALE_WIDTH 4'h1
`define EBT_RST_NARROW_CMD 4'h1
`define EBT_RST_NARROW_WAIT 4'h4
`define EBT_RST_WIDE_IO_WAIT 4'h1
`define EBT_RST_WIDE_MEM_CMD 4'h0
`define EBT_RST_WIDE_MEM_WAIT 4'h1
`define EBT_RST_ZW_MIN 4'h0
`define EBT_RST_CONTROL 1'b1

// status register field positions
`define EBT_ST_BUSY 0
`define EBT_ST_WIDE 1
`define EBT_ST_CMD 2
`define EBT_ST_BALE 3
`define EBT_ST_TCNT_LO 8
`define EBT_ST_TCNT_HI 12

// processor clock half period in clk_sys cycles
`define EBT_PROC_HALF 2

`endif

// [logic/ebt_cycle_timing.v]
// expansion bus cycle timing: bale, command strobes, wait states, card responses
// Function
// - sample zero-wait request at the middle of each cpu wait state
// - zero-wait sampled after minimum wait count ends the cycle early
// - 16-bit memory select input used only in memory cycles
// - 16-bit io select input used only in io cycles
// - sample ready on the processor clock falling edge ending each state
// - ready low one whole state before normal end stretches the cycle
// - all processor-clock referenced outputs change on its falling edge
// - bale starts after programmed delay and stays high programmed width
// - separate command delays for 16-bit memory and for narrow/io cycles
// - three wait counts: narrow, 16-bit io, 16-bit memory
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "ebt_consts.vh"

module ebt_cycle_timing #(
    parameter PROC_HALF = `EBT_PROC_HALF
) (
    input wire clk_sys,
    input wire rst_n,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // cpu side request, held high until cycle_done
    input wire cpu_cycle_req,
    input wire cpu_cycle_io,
    output reg cycle_done,
    // expansion bus
    input wire memcs16_n,
    input wire iocs16_n,
    input wire iochrdy,
    input wire zero_wait_request_n,
    output reg processor_clock,
    output reg bale,
    output reg mem_cmd_n,
    output reg io_cmd_n,
    output reg bus_16bit
);

    localparam ST_IDLE = 1'b0;
    localparam ST_ACTIVE = 1'b1;
    localparam DIV_W = 8;

    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_int_n;

    // reset released through two flops
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_int_n = rst_s2_q;

    // two-flop synchronisers for pins; first stage read only by the second
    reg [5:0] pin_s1_q;
    reg [5:0] pin_s2_q;
    wire req_s;
    wire io_s;
    wire memcs_s;
    wire iocs_s;
    wire rdy_s;
    wire zw_s;

    always @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            pin_s1_q <= 6'h3c;
            pin_s2_q <= 6'h3c;
        end
        else
        begin
            pin_s1_q <= {zero_wait_request_n, iochrdy, iocs16_n, memcs16_n,
                         cpu_cycle_io, cpu_cycle_req};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign req_s = pin_s2_q[0];
    assign io_s = pin_s2_q[1];
    assign memcs_s = ~pin_s2_q[2];
    assign iocs_s = ~pin_s2_q[3];
    assign rdy_s = pin_s2_q[4];
    assign zw_s = ~pin_s2_q[5];

    // processor clock divider: fall tick ends a state, mid tick splits it
    reg [DIV_W-1:0] div_q;
    reg fall_tick_q;
    reg mid_tick_q;
    wire [DIV_W-1:0] half_w;

    assign half_w = PROC_HALF[DIV_W-1:0];

    always @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            div_q <= {DIV_W{1'b0}};
            processor_clock <= 1'b1;
            fall_tick_q <= 1'b0;
            mid_tick_q <= 1'b0;
        end
        else
        begin
            fall_tick_q <= 1'b0;
            mid_tick_q <= 1'b0;
            if (div_q == half_w + half_w - 1'b1)
            begin
                div_q <= {DIV_W{1'b0}};
                processor_clock <= 1'b1;
            end
            else
            begin
                div_q <= div_q + 1'b1;
                if (div_q == half_w - 1'b1)
                begin
                    processor_clock <= 1'b0; // falling edge of the state
                    fall_tick_q <= 1'b1;
                end
            end
            // midpoint of the low-going state, half a state after the fall
            if (div_q == half_w + half_w - 1'b1)
                mid_tick_q <= 1'b1;
        end
    end

    // settings registers
    reg [`EBT_SET_W-1:0] bale_delay_setting;
    reg [`EBT_SET_W-1:0] bale_width_setting;
    reg [`EBT_SET_W-1:0] narrow_command_delay_setting;
    reg [`EBT_SET_W-1:0] narrow_wait_count_setting;
    reg [`EBT_SET_W-1:0] wide_io_wait_count_setting;
    reg [`EBT_SET_W-1:0] wide_memory_command_delay_setting;
    reg [`EBT_SET_W-1:0] wide_memory_wait_count_setting;
    reg [`EBT_SET_W-1:0] zero_wait_minimum_setting;
    reg enable_q;

    // cycle state
    reg state_q;
    reg io_q;
    reg known_q;
    reg wide_q;
    reg zw_hit_q;
    reg rdy_prev_q;
    reg [4:0] t_q;
    reg [4:0] w_q;

    // avalon slave: waitrequest drops for one cycle, access done at that edge
    reg [31:0] rd_d;
    wire bus_req;
    wire bus_take;

    assign bus_req = avs_read | avs_write;
    assign bus_take = bus_req & ~avs_waitrequest;

    always @*
    begin
        rd_d = 32'h0;
        case (avs_address)
            `EBT_IDX_BALE_DELAY: rd_d[`EBT_SET_W-1:0] = bale_delay_setting;
            `EBT_IDX_BALE_WIDTH: rd_d[`EBT_SET_W-1:0] = bale_width_setting;
            `EBT_IDX_NARROW_CMD: rd_d[`EBT_SET_W-1:0] = narrow_command_delay_setting;
            `EBT_IDX_NARROW_WAIT: rd_d[`EBT_SET_W-1:0] = narrow_wait_count_setting;
            `EBT_IDX_WIDE_IO_WAIT: rd_d[`EBT_SET_W-1:0] = wide_io_wait_count_setting;
            `EBT_IDX_WIDE_MEM_CMD: rd_d[`EBT_SET_W-1:0] = wide_memory_command_delay_setting;
            `EBT_IDX_WIDE_MEM_WAIT: rd_d[`EBT_SET_W-1:0] = wide_memory_wait_count_setting;
            `EBT_IDX_ZW_MIN: rd_d[`EBT_SET_W-1:0] = zero_wait_minimum_setting;
            `EBT_IDX_CONTROL: rd_d[0] = enable_q;
            `EBT_IDX_STATUS:
            begin
                rd_d[`EBT_ST_BUSY] = state_q;
                rd_d[`EBT_ST_WIDE] = wide_q;
                rd_d[`EBT_ST_CMD] = ~(mem_cmd_n & io_cmd_n);
                rd_d[`EBT_ST_BALE] = bale;
                rd_d[`EBT_ST_TCNT_HI:`EBT_ST_TCNT_LO] = t_q;
            end
            default: rd_d = 32'h0; // unmapped reads as zero
        endcase
    end

    // bus handshake and register writes; settings may change mid cycle
    always @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            bale_delay_setting <= `EBT_RST_BALE_DELAY;
            bale_width_setting <= `EBT_RST_BALE_WIDTH;
            narrow_command_delay_setting <= `EBT_RST_NARROW_CMD;
            narrow_wait_count_setting <= `EBT_RST_NARROW_WAIT;
            wide_io_wait_count_setting <= `EBT_RST_WIDE_IO_WAIT;
            wide_memory_command_delay_setting <= `EBT_RST_WIDE_MEM_CMD;
            wide_memory_wait_count_setting <= `EBT_RST_WIDE_MEM_WAIT;
            zero_wait_minimum_setting <= `EBT_RST_ZW_MIN;
            enable_q <= `EBT_RST_CONTROL;
        end
        else
        begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (bus_req & avs_waitrequest)
                avs_readdata <= rd_d;
            if (bus_take & avs_write)
            begin
                case (avs_address)
                    `EBT_IDX_BALE_DELAY:
                        bale_delay_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_BALE_WIDTH:
                        bale_width_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_NARROW_CMD:
                        narrow_command_delay_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_NARROW_WAIT:
                        narrow_wait_count_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_WIDE_IO_WAIT:
                        wide_io_wait_count_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_WIDE_MEM_CMD:
                        wide_memory_command_delay_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_WIDE_MEM_WAIT:
                        wide_memory_wait_count_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_ZW_MIN:
                        zero_wait_minimum_setting <= avs_writedata[`EBT_SET_W-1:0];
                    `EBT_IDX_CONTROL:
                        enable_q <= avs_writedata[0];
                    default:
                        enable_q <= enable_q; // unmapped writes ignored
                endcase
            end
        end
    end

    // timing points derived from the settings
    wire [4:0] bale_start;
    wire [4:0] bale_end;
    wire [4:0] mem_decide;
    wire [4:0] decide_pt;
    wire sel_now;
    wire known_now;
    wire wide_now;
    wire [4:0] cmd_dly;
    wire [4:0] wait_lim;
    wire [4:0] t_next;
    wire cmd_on;
    wire end_due;

    assign bale_start = {1'b0, bale_delay_setting};
    assign bale_end = {1'b0, bale_delay_setting} + {1'b0, bale_width_setting};
    // memory select must be valid by the earlier of command fall or bale fall
    assign mem_decide = ({1'b0, wide_memory_command_delay_setting} < bale_end) ?
                        {1'b0, wide_memory_command_delay_setting} : bale_end;
    assign decide_pt = io_q ? {1'b0, narrow_command_delay_setting} : mem_decide;
    // only the select input matching the cycle type is looked at
    assign sel_now = io_q ? iocs_s : memcs_s;
    assign known_now = known_q | (t_q >= decide_pt);
    assign wide_now = known_q ? wide_q : sel_now;
    assign cmd_dly = (!io_q && wide_now) ? {1'b0, wide_memory_command_delay_setting} :
                     {1'b0, narrow_command_delay_setting};
    assign wait_lim = !wide_now ? {1'b0, narrow_wait_count_setting} :
                      io_q ? {1'b0, wide_io_wait_count_setting} :
                      {1'b0, wide_memory_wait_count_setting};
    assign t_next = t_q + 5'h01;
    assign cmd_on = ~(mem_cmd_n & io_cmd_n);
    // rdy_prev_q was taken one full state earlier; low there stretches
    assign end_due = cmd_on & ((w_q >= wait_lim) | zw_hit_q) & rdy_prev_q;

    // cycle sequencer; every bus output moves only on the fall tick
    always @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            state_q <= ST_IDLE;
            io_q <= 1'b0;
            known_q <= 1'b0;
            wide_q <= 1'b0;
            zw_hit_q <= 1'b0;
            rdy_prev_q <= 1'b1;
            t_q <= 5'h00;
            w_q <= 5'h00;
            bale <= 1'b0;
            mem_cmd_n <= 1'b1;
            io_cmd_n <= 1'b1;
            bus_16bit <= 1'b0;
            cycle_done <= 1'b0;
        end
        else
        begin
            cycle_done <= 1'b0;
            // zero-wait looked at only mid state once command runs
            if (mid_tick_q && state_q == ST_ACTIVE && cmd_on && zw_s &&
                w_q >= {1'b0, zero_wait_minimum_setting})
                zw_hit_q <= 1'b1;
            if (fall_tick_q)
            begin
                rdy_prev_q <= rdy_s;
                case (state_q)
                    ST_IDLE:
                    begin
                        // a fresh cycle recomputes bale, no carry from before
                        bale <= 1'b0;
                        if (req_s && enable_q && !cycle_done)
                        begin
                            state_q <= ST_ACTIVE;
                            io_q <= io_s;
                            known_q <= 1'b0;
                            wide_q <= 1'b0;
                            zw_hit_q <= 1'b0;
                            t_q <= 5'h00;
                            w_q <= 5'h00;
                            bale <= (bale_start == 5'h00) && (bale_end != 5'h00);
                        end
                    end
                    ST_ACTIVE:
                    begin
                        t_q <= t_next;
                        bale <= (t_next >= bale_start) && (t_next < bale_end);
                        if (known_now && !known_q)
                        begin
                            known_q <= 1'b1;
                            wide_q <= sel_now;
                            bus_16bit <= sel_now;
                        end
                        if (end_due)
                        begin
                            mem_cmd_n <= 1'b1;
                            io_cmd_n <= 1'b1;
                            cycle_done <= 1'b1;
                            bale <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                        else if (cmd_on)
                            w_q <= w_q + 5'h01;
                        else if (known_now && t_q >= cmd_dly)
                        begin
                            mem_cmd_n <= io_q;
                            io_cmd_n <= ~io_q;
                        end
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // ebt_cycle_timing
`default_nettype wire

// [sim/ebt_chk.sv]
// assertion checker for the expansion bus cycle timing block
`timescale 1ns/10ps
`default_nettype none
module ebt_chk #(
    parameter PROC_HALF = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic cycle_done,
    input wire logic processor_clock,
    input wire logic bale,
    input wire logic mem_cmd_n,
    input wire logic io_cmd_n,
    input wire logic bus_16bit
);
    logic [3:0] bw_q;
    logic [7:0] hi_q;
    // shadow of the bale width setting and a count of bale high cycles
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bw_q <= 4'h1;
            hi_q <= 8'h00;
        end
        else
        begin
            if (avs_write && !avs_waitrequest && avs_address == 4'h1)
                bw_q <= avs_writedata[3:0];
            hi_q <= bale ? hi_q + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_ack_one: assert property (p_ack_one) else $error("waitrequest low too long");
    property p_bale_edge; $changed(bale) |-> !processor_clock; endproperty
    a_bale_edge: assert property (p_bale_edge) else $error("bale off clock fall");
    property p_cmd_edge; $changed(mem_cmd_n) || $changed(io_cmd_n) |-> !processor_clock; endproperty
    a_cmd_edge: assert property (p_cmd_edge) else $error("strobe off clock fall");
    property p_one_cmd; mem_cmd_n || io_cmd_n; endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("both strobes low");
    property p_done; cycle_done |-> mem_cmd_n && io_cmd_n ##1 !cycle_done; endproperty
    a_done: assert property (p_done) else $error("done with strobe low");
    property p_bale_w; $fell(bale) |-> hi_q == bw_q * 2 * PROC_HALF; endproperty
    a_bale_w: assert property (p_bale_w) else $error("bale width wrong");
    property p_bale_rise; $rose(bale) |-> mem_cmd_n && io_cmd_n; endproperty
    a_bale_rise: assert property (p_bale_rise) else $error("bale inside command");
    property p_w_hold; (!mem_cmd_n && $past(!mem_cmd_n)) || (!io_cmd_n && $past(!io_cmd_n))
        |-> $stable(bus_16bit); endproperty
    a_w_hold: assert property (p_w_hold) else $error("width moved in command");
endmodule // ebt_chk
`default_nettype wire

// [sim/ebt_card.sv]
// adapter card model: 16-bit selects, ready stretch, zero-wait request
`timescale 1ns/10ps
`default_nettype none
module ebt_card (
    input wire logic clk_sys,
    input wire logic processor_clock,
    input wire logic bale,
    input wire logic mem_cmd_n,
    input wire logic io_cmd_n,
    input wire logic cs_mem,
    input wire logic cs_io,
    input wire logic zw_en,
    input wire logic [3:0] hold_st,
    output logic memcs16_n,
    output logic iocs16_n,
    output logic iochrdy,
    output logic zero_wait_request_n
);
    logic act_q = 1'b0;
    logic cmd_q = 1'b0;
    logic pc_q = 1'b1;
    logic [3:0] st_q = 4'h0;
    wire cmd = !mem_cmd_n || !io_cmd_n;
    // selects valid from bale rise to cycle end, pulled up high otherwise
    assign memcs16_n = !((bale || act_q) && cs_mem);
    assign iocs16_n = !((bale || act_q) && cs_io);
    assign zero_wait_request_n = !(zw_en && cmd);
    // released ready floats to its pull-up level outside the command
    assign iochrdy = !cmd || st_q == 4'h0;
    // ready pulled low at command start, long before the normal end
    always @(posedge clk_sys)
    begin
        pc_q <= processor_clock;
        cmd_q <= cmd;
        if (bale)
            act_q <= 1'b1;
        else if (cmd_q && !cmd)
            act_q <= 1'b0;
        if (!cmd)
            st_q <= hold_st;
        else if (pc_q && !processor_clock && st_q != 4'h0)
            st_q <= st_q - 4'h1;
    end
endmodule // ebt_card
`default_nettype wire

// [sim/testbench.sv]
// testbench for the expansion bus cycle timing block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int P = 4; // clk_sys cycles per processor state
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0, cpu_cycle_req = 1'b0, cpu_cycle_io = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic cs_mem = 1'b0, cs_io = 1'b0, zw_en = 1'b0, sm;
    logic [3:0] hold_st = 4'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, cycle_done, processor_clock, bale, mem_cmd_n, io_cmd_n, bus_16bit;
    wire memcs16_n, iocs16_n, iochrdy, zero_wait_request_n;
    logic [31:0] rd;
    logic [3:0] rv [10] = '{4'h0, 4'h1, 4'h0, 4'h1, 4'h4, 4'h1, 4'h0, 4'h1, 4'h0, 4'h1};
    logic [7:0] fast [8] = '{8'h54, 8'h62, 8'h74, 8'h82, 8'h4a, 8'h34, 8'h12, 8'h01};
    logic [7:0] slow [8] = '{8'h51, 8'h60, 8'h71, 8'h80, 8'h00, 8'h11, 8'h31, 8'h44};
    int err_count = 0, n_checks = 0, tick = 0, len, gap;
    ebt_cycle_timing #(.PROC_HALF(2)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_cycle_req(cpu_cycle_req),
        .cpu_cycle_io(cpu_cycle_io), .cycle_done(cycle_done), .memcs16_n(memcs16_n),
        .iocs16_n(iocs16_n), .iochrdy(iochrdy), .zero_wait_request_n(zero_wait_request_n),
        .processor_clock(processor_clock), .bale(bale), .mem_cmd_n(mem_cmd_n),
        .io_cmd_n(io_cmd_n), .bus_16bit(bus_16bit));
    ebt_card i_card (.clk_sys(clk_sys), .processor_clock(processor_clock), .bale(bale),
        .mem_cmd_n(mem_cmd_n), .io_cmd_n(io_cmd_n), .cs_mem(cs_mem), .cs_io(cs_io),
        .zw_en(zw_en), .hold_st(hold_st), .memcs16_n(memcs16_n), .iocs16_n(iocs16_n),
        .iochrdy(iochrdy), .zero_wait_request_n(zero_wait_request_n));
    // free-running clock and a hang limit
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        tick <= tick + 1;
        if (tick == 20000)
        begin
            err_count++;
            stop_test;
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t value %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi);
        n_checks++;
        if (v < lo || v > hi)
        begin
            err_count++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    // one avalon transfer held until waitrequest is seen low
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    // one bus cycle; measures strobe length and bale-to-strobe distance
    task automatic cyc(input logic io);
        int t, b;
        cpu_cycle_io <= io;
        cpu_cycle_req <= 1'b1;
        len = 0;
        t = 0;
        b = 0;
        sm = 1'b0;
        while (cycle_done !== 1'b1)
        begin
            @(posedge clk_sys);
            t++;
            if (bale === 1'b1 && b == 0)
                b = t;
            if (mem_cmd_n === 1'b0)
                sm = 1'b1;
            if ((mem_cmd_n & io_cmd_n) === 1'b0)
            begin
                if (len == 0)
                    gap = t - b;
                len++;
            end
        end
        cpu_cycle_req <= 1'b0;
        repeat (2 * P) @(posedge clk_sys);
    endtask
    task automatic run(input logic io, m, s, w, input int lo, input int hi);
        cs_mem <= m;
        cs_io <= s;
        cyc(io);
        chk({31'h0, bus_16bit}, {31'h0, w});
        chk({31'h0, sm}, {31'h0, !io});
        // the strobe holds one base state, then the counted wait states
        chk_rng(len, (lo + 1) * P, (hi + 1) * P);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 10; i++)
        begin
            acc(1'b0, 4'(i), 32'h0);
            chk(rd, {28'h0, rv[i]});
        end
        acc(1'b1, 4'h2, 32'hf);
        acc(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        acc(1'b1, 4'ha, 32'hf);
        acc(1'b0, 4'ha, 32'h0);
        chk(rd & 32'hf, 32'h0);
        $display("test registers done");
        run(0, 0, 0, 0, 4, 4);
        // bale rises in the state of its delay, the strobe one state after its own
        chk_rng(gap, 2 * P, 2 * P);
        run(0, 1, 0, 1, 1, 1);
        run(1, 1, 0, 0, 4, 4);
        run(1, 0, 1, 1, 1, 1);
        run(0, 0, 1, 0, 4, 4);
        $display("test widths done");
        hold_st <= 4'h6;
        run(0, 0, 0, 0, 6, 8);
        hold_st <= 4'h0;
        acc(1'b1, 4'h8, 32'h2);
        zw_en <= 1'b1;
        run(0, 0, 0, 0, 2, 3);
        zw_en <= 1'b0;
        $display("test ready and early end done");
        for (int i = 0; i < 8; i++)
            acc(1'b1, fast[i][7:4], {28'h0, fast[i][3:0]});
        run(0, 0, 0, 0, 10, 10);
        chk_rng(gap, 4 * P, 4 * P);
        run(0, 1, 0, 1, 4, 4);
        chk_rng(gap, 2 * P, 2 * P);
        acc(1'b1, 4'h4, 32'h8);
        run(0, 0, 0, 0, 8, 8);
        for (int i = 0; i < 8; i++)
            acc(1'b1, slow[i][7:4], {28'h0, slow[i][3:0]});
        run(0, 0, 0, 0, 4, 4);
        $display("test profiles done");
        stop_test;
    end
endmodule // testbench
bind ebt_cycle_timing ebt_chk #(.PROC_HALF(PROC_HALF)) i_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .cycle_done(cycle_done), .processor_clock(processor_clock), .bale(bale),
    .mem_cmd_n(mem_cmd_n), .io_cmd_n(io_cmd_n), .bus_16bit(bus_16bit));
`default_nettype wire
